// [rtl/scr_pkg.sv]
package scr_pkg;

  // ---------------------------------------------------------------
  // clock and reference rates
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int AES_MIN_HZ = 32_000;
  localparam int AES_MAX_HZ = 192_000;
  localparam int VID_MIN_HZ = 15_000;
  localparam int VID_MAX_HZ = 70_000;
  localparam int AES_PER_MIN = CLK_HZ / AES_MAX_HZ;
  localparam int AES_PER_MAX = CLK_HZ / AES_MIN_HZ;
  localparam int VID_PER_MIN = CLK_HZ / VID_MAX_HZ;
  localparam int VID_PER_MAX = CLK_HZ / VID_MIN_HZ;
  localparam logic [15:0] PER_TOL = 16'h0004;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_RATE_DIV = 5'h04;
  localparam logic [4:0] REG_QUAL = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_IRQ_STAT = 5'h10;
  localparam logic [4:0] REG_IRQ_MASK = 5'h14;

  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_PLAY_BIT = 3;
  localparam int CTRL_REC_BIT = 4;
  localparam logic [15:0] RATE_DIV_RST = 16'h0A2C;
  localparam logic [7:0] QUAL_RST = 8'h10;

  localparam int IRQ_LOCK_GAIN = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_FALLBACK = 2;

  typedef enum logic [2:0] {
    SRC_INTERNAL = 3'b000,
    SRC_WORD = 3'b001,
    SRC_VIDEO = 3'b010,
    SRC_AES12 = 3'b011,
    SRC_AES34 = 3'b100,
    SRC_AES56 = 3'b101,
    SRC_AES78 = 3'b110
  } scr_src_t;

  typedef enum logic [1:0] {
    LK_UNLOCKED = 2'b00,
    LK_QUALIFY = 2'b01,
    LK_LOCKED = 2'b10
  } scr_lock_t;

endpackage

// [rtl/scr_sample_clock_select.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_sample_clock_select #(
  parameter int FLASH_CYC = scr_pkg::FLASH_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic word_clk_in,
  input wire logic video_sync_in,
  input wire logic [3:0] aes_rate_in,
  output logic word_clk_out,
  output logic aes_frame_sync,
  output logic rate_converter_en,
  output logic lock_word,
  output logic lock_video,
  output logic lock_digital,
  output logic [3:0] ring_flash,
  output logic irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] ref_index(input scr_pkg::scr_src_t s);
    return 3'(s) - 3'b001;
  endfunction

  function automatic logic period_ok(input scr_pkg::scr_src_t s, input logic [15:0] p);
    if (s == scr_pkg::SRC_VIDEO) begin
      return (p >= 16'(scr_pkg::VID_PER_MIN)) && (p <= 16'(scr_pkg::VID_PER_MAX));
    end
    return (p >= 16'(scr_pkg::AES_PER_MIN)) && (p <= 16'(scr_pkg::AES_PER_MAX));
  endfunction

  // period jitter of either sign
  function automatic logic [15:0] per_gap(input logic [15:0] a, input logic [15:0] b);
    return (a >= b) ? a - b : b - a;
  endfunction

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  scr_pkg::scr_src_t src, next_src;
  logic playback, next_playback, recording, next_recording;
  logic [15:0] rate_div, next_rate_div;
  logic [7:0] qual, next_qual;
  logic [2:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, irq_set;
  logic [31:0] next_readdata, wdat;
  logic next_waitrequest, next_irq, acc;
  scr_pkg::scr_lock_t lk, next_lk;
  logic [15:0] per_cnt, per_last;

  assign acc = (avs_read || avs_write) && !avs_waitrequest;

  always_comb begin
    next_src = src;
    next_playback = playback;
    next_recording = recording;
    next_rate_div = rate_div;
    next_qual = qual;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat | irq_set;
    next_readdata = avs_readdata;
    wdat = 32'h0000_0000;
    // one wait cycle, then the answer stands for the accepting edge
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
    if (avs_read && avs_waitrequest) begin
      case (avs_address & 5'h1C)
        scr_pkg::REG_CTRL:
          next_readdata = {27'h000_0000, recording, playback, 3'(src)};
        scr_pkg::REG_RATE_DIV: next_readdata = {16'h0000, rate_div};
        scr_pkg::REG_QUAL: next_readdata = {24'h00_0000, qual};
        scr_pkg::REG_STATUS: next_readdata = {per_last, 10'h000, 2'(lk), rate_converter_en,
                                              lock_digital, lock_video, lock_word};
        scr_pkg::REG_IRQ_STAT: next_readdata = {29'h0000_0000, irq_stat};
        scr_pkg::REG_IRQ_MASK: next_readdata = {29'h0000_0000, irq_mask};
        default: next_readdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && acc) begin
      case (avs_address & 5'h1C)
        scr_pkg::REG_CTRL: begin
          wdat = be_merge({27'h000_0000, recording, playback, 3'(src)}, avs_writedata,
                          avs_byteenable);
          if (wdat[2:0] <= 3'(scr_pkg::SRC_AES78)) begin
            next_src = scr_pkg::scr_src_t'(wdat[scr_pkg::CTRL_SRC_LSB +: 3]);
          end
          next_playback = wdat[scr_pkg::CTRL_PLAY_BIT];
          next_recording = wdat[scr_pkg::CTRL_REC_BIT];
        end
        scr_pkg::REG_RATE_DIV: begin
          wdat = be_merge({16'h0000, rate_div}, avs_writedata, avs_byteenable);
          // below two cycles the square wave cannot exist
          next_rate_div = (wdat[15:0] < 16'h0002) ? 16'h0002 : wdat[15:0];
        end
        scr_pkg::REG_QUAL: begin
          wdat = be_merge({24'h00_0000, qual}, avs_writedata, avs_byteenable);
          next_qual = wdat[7:0];
        end
        scr_pkg::REG_IRQ_STAT: begin
          wdat = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
          // set wins over clear
          next_irq_stat = (irq_stat & ~wdat[2:0]) | irq_set;
        end
        scr_pkg::REG_IRQ_MASK: begin
          wdat = be_merge({29'h0000_0000, irq_mask}, avs_writedata, avs_byteenable);
          next_irq_mask = wdat[2:0];
        end
        default: wdat = 32'h0000_0000;
      endcase
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      src <= scr_pkg::SRC_INTERNAL;
      playback <= 1'b0;
      recording <= 1'b0;
      rate_div <= scr_pkg::RATE_DIV_RST;
      qual <= scr_pkg::QUAL_RST;
      irq_stat <= 3'b000;
      irq_mask <= 3'b000;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
    end else begin
      src <= next_src;
      playback <= next_playback;
      recording <= next_recording;
      rate_div <= next_rate_div;
      qual <= next_qual;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // reference sampling and qualification
  // ---------------------------------------------------------------
  logic [5:0] ref_meta, ref_sync, ref_prev;
  logic sel_rise, sel_lvl, ext_sel;
  logic [7:0] stable, next_stable;
  logic [15:0] next_per_cnt, next_per_last;
  scr_pkg::scr_src_t src_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_meta <= 6'h00;
      ref_sync <= 6'h00;
      ref_prev <= 6'h00;
    end else begin
      ref_meta <= {aes_rate_in, video_sync_in, word_clk_in};
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end

  // internal or playback means no external reference
  assign ext_sel = (src != scr_pkg::SRC_INTERNAL) && !playback;
  assign sel_lvl = ext_sel ? ref_sync[ref_index(src)] : 1'b0;
  assign sel_rise = sel_lvl && !ref_prev[ref_index(src)];

  always_comb begin
    next_lk = lk;
    next_stable = stable;
    next_per_last = per_last;
    next_per_cnt = (per_cnt == 16'hFFFF) ? per_cnt : per_cnt + 16'h0001;
    if (!ext_sel || src != src_q) begin
      next_lk = scr_pkg::LK_UNLOCKED;
      next_stable = 8'h00;
      next_per_cnt = 16'h0000;
    end else if (sel_rise) begin
      next_per_cnt = 16'h0001;
      next_per_last = per_cnt;
      if (period_ok(src, per_cnt) && (per_gap(per_cnt, per_last) <= scr_pkg::PER_TOL)) begin
        next_stable = (stable == 8'hFF) ? stable : stable + 8'h01;
        next_lk = (next_stable >= qual) ? scr_pkg::LK_LOCKED : scr_pkg::LK_QUALIFY;
      end else begin
        next_stable = 8'h00;
        next_lk = scr_pkg::LK_UNLOCKED;
      end
    end else if (!period_ok(src, per_cnt) && per_cnt > 16'(scr_pkg::VID_PER_MIN)
                 && per_cnt > (src == scr_pkg::SRC_VIDEO ? 16'(scr_pkg::VID_PER_MAX)
                                                         : 16'(scr_pkg::AES_PER_MAX))) begin
      next_stable = 8'h00;
      next_lk = scr_pkg::LK_UNLOCKED;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lk <= scr_pkg::LK_UNLOCKED;
      stable <= 8'h00;
      per_cnt <= 16'h0000;
      per_last <= 16'h0000;
      src_q <= scr_pkg::SRC_INTERNAL;
    end else begin
      lk <= next_lk;
      stable <= next_stable;
      per_cnt <= next_per_cnt;
      per_last <= next_per_last;
      src_q <= src;
    end
  end

  // ---------------------------------------------------------------
  // sample clock generation and outputs
  // ---------------------------------------------------------------
  logic [15:0] gen_cnt, next_gen_cnt;
  logic gen_wrap, locked, next_word, next_tick, next_rc, fallback, lock_any_q;
  logic [25:0] fl_cnt, next_fl_cnt;
  logic blink, next_blink;
  logic [3:0] next_ring;

  // a lock counts only for the source it was qualified on, not the new one
  assign locked = (lk == scr_pkg::LK_LOCKED) && ext_sel && (src == src_q);
  assign gen_wrap = gen_cnt >= rate_div - 16'h0001;
  assign fallback = ext_sel && !locked;
  assign lock_any_q = lock_word || lock_video || lock_digital;

  always_comb begin
    // generator realigns to the reference so that a fallback is near phase
    next_gen_cnt = (gen_wrap || (locked && sel_rise)) ? 16'h0000 : gen_cnt + 16'h0001;
    // generator only unless a reference is qualified
    next_tick = locked ? sel_rise : gen_wrap;
    // square wave on word out in every mode
    next_word = locked ? sel_lvl : (gen_cnt < (rate_div >> 1));
    next_rc = (src == scr_pkg::SRC_INTERNAL);
    next_fl_cnt = (fl_cnt >= 26'(FLASH_CYC - 1)) ? 26'h000_0000 : fl_cnt + 26'h000_0001;
    next_blink = (fl_cnt >= 26'(FLASH_CYC - 1)) ? !blink : blink;
    next_ring = 4'h0;
    // all rings flash without a valid word or video reference
    if (fallback && (src == scr_pkg::SRC_WORD || src == scr_pkg::SRC_VIDEO)) begin
      next_ring = {4{next_blink}};
    end
    // only the selected pair's ring flashes
    if (fallback && src >= scr_pkg::SRC_AES12) begin
      next_ring[2'(ref_index(src) - 3'b010)] = next_blink;
    end
    irq_set = {fallback && recording && !(lk == scr_pkg::LK_LOCKED) && lock_any_q,
               (lk == scr_pkg::LK_LOCKED) && (next_lk != scr_pkg::LK_LOCKED),
               (lk != scr_pkg::LK_LOCKED) && (next_lk == scr_pkg::LK_LOCKED)};
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gen_cnt <= 16'h0000;
      fl_cnt <= 26'h000_0000;
      blink <= 1'b0;
      word_clk_out <= 1'b0;
      aes_frame_sync <= 1'b0;
      rate_converter_en <= 1'b1;
      lock_word <= 1'b0;
      lock_video <= 1'b0;
      lock_digital <= 1'b0;
      ring_flash <= 4'h0;
    end else begin
      gen_cnt <= next_gen_cnt;
      fl_cnt <= next_fl_cnt;
      blink <= next_blink;
      word_clk_out <= next_word;
      // frame strobe for the AES output framer
      aes_frame_sync <= next_tick;
      rate_converter_en <= next_rc;
      lock_word <= locked && src == scr_pkg::SRC_WORD;
      lock_video <= locked && src == scr_pkg::SRC_VIDEO;
      lock_digital <= locked && src >= scr_pkg::SRC_AES12;
      ring_flash <= next_ring;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [15:0] wo_idle;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wo_idle <= 16'h0000;
    end else begin
      wo_idle <= (word_clk_out != next_word) ? 16'h0000 : wo_idle + 16'h0001;
    end
  end

  chk_rc_enable: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 rate_converter_en == ($past(src) == scr_pkg::SRC_INTERNAL))
    else $error("converter enable does not follow internal selection");
  chk_internal_tick: assert property (@(posedge mclk) disable iff (sys_rst)
    !ext_sel |=> aes_frame_sync == $past(gen_wrap))
    else $error("internal mode tick not from generator");
  chk_play_nolock: assert property (@(posedge mclk) disable iff (sys_rst)
    playback ##1 playback |-> !lock_word && !lock_video && !lock_digital)
    else $error("lock shown during playback");
  chk_word_lock: assert property (@(posedge mclk) disable iff (sys_rst)
    lock_word |-> $past(locked) && $past(src) == scr_pkg::SRC_WORD)
    else $error("word lock without qualified word reference");
  chk_video_lock: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(lock_video) |-> $past(src) == scr_pkg::SRC_VIDEO && ring_flash == 4'h0)
    else $error("video lock without video reference");
  chk_aes_lock: assert property (@(posedge mclk) disable iff (sys_rst)
    lock_digital |-> ring_flash == 4'h0)
    else $error("ring flashes while digital lock is shown");
  chk_qual_count: assert property (@(posedge mclk) disable iff (sys_rst)
    (lk != scr_pkg::LK_LOCKED) ##1 (lk == scr_pkg::LK_LOCKED) |-> stable >= qual)
    else $error("lock taken before qualification count");
  chk_aes_range: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(lock_digital) |-> per_last >= 16'(scr_pkg::AES_PER_MIN)
      && per_last <= 16'(scr_pkg::AES_PER_MAX))
    else $error("digital lock outside accepted rate range");
  chk_fallback: assert property (@(posedge mclk) disable iff (sys_rst)
    locked ##1 !locked |=> aes_frame_sync == $past(gen_wrap))
    else $error("no fallback to generator after loss");
  chk_word_out: assert property (@(posedge mclk) disable iff (sys_rst)
    !ext_sel |-> wo_idle < 16'hFFF0)
    else $error("word clock output stalled");
  chk_frame_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    aes_frame_sync && !locked |=> !aes_frame_sync)
    else $error("frame strobe longer than one cycle");

endmodule
`default_nettype wire

// [tb/scr_ref_src.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_ref_src (
  input wire logic [5:0] run,
  input wire logic [31:0] half_ns,
  output logic word_clk_in,
  output logic video_sync_in,
  output logic [3:0] aes_rate_in
);
  logic [5:0] line;

  // ---------------------------------------------------------------
  // reference sources: word, video, aes pairs 1-2..7-8
  // ---------------------------------------------------------------
  // steady while running
  // a stopped source rests low, as a terminated sync line does
  for (genvar g = 0; g < 6; g++) begin : g_src
    initial begin
      line[g] = 1'b0;
      forever begin
        if (run[g] === 1'b1) begin
          #(half_ns) line[g] = ~line[g];
        end else begin
          line[g] = 1'b0;
          @(run[g]);
          // keeps reference edges clear of the sampling clock edge
          #1;
        end
      end
    end
  end

  assign word_clk_in = line[0];
  assign video_sync_in = line[1];
  assign aes_rate_in = line[5:2];
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, half_ns, q;
  logic word_clk_in, video_sync_in, word_clk_out, aes_frame_sync, rate_converter_en;
  logic [3:0] aes_rate_in, ring_flash, ring_or;
  logic lock_word, lock_video, lock_digital, irq;
  logic [2:0] locks, lock_or;
  logic [5:0] run;
  int error_cnt, checks_done, cyc, wc_rise, wc_high, fs_cnt;

  assign locks = {lock_digital, lock_video, lock_word};

  scr_sample_clock_select #(.FLASH_CYC(16)) scr_sample_clock_select_i (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .word_clk_in(word_clk_in), .video_sync_in(video_sync_in), .aes_rate_in(aes_rate_in),
    .word_clk_out(word_clk_out), .aes_frame_sync(aes_frame_sync),
    .rate_converter_en(rate_converter_en), .lock_word(lock_word),
    .lock_video(lock_video), .lock_digital(lock_digital), .ring_flash(ring_flash),
    .irq(irq));

  scr_ref_src scr_ref_src_i (.run(run), .half_ns(half_ns), .word_clk_in(word_clk_in),
    .video_sync_in(video_sync_in), .aes_rate_in(aes_rate_in));

  // ---------------------------------------------------------------
  // clock, timeout and verdict
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // budget: roughly 70k cycles of lock waits and watch windows plus margin
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      error_cnt++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one access; waitrequest is sampled at each edge, request held until low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(q & m, e);
  endtask

  task automatic watch(input int n);
    logic prev;
    prev = word_clk_out;
    wc_rise = 0;
    wc_high = 0;
    fs_cnt = 0;
    ring_or = '0;
    lock_or = '0;
    repeat (n) begin
      @(posedge mclk);
      if (word_clk_out === 1'b1 && prev === 1'b0) wc_rise++;
      if (word_clk_out === 1'b1) wc_high++;
      if (aes_frame_sync === 1'b1) fs_cnt++;
      ring_or = ring_or | ring_flash;
      lock_or = lock_or | locks;
      prev = word_clk_out;
    end
  endtask

  task automatic wait_lock(input int idx, input logic exp);
    int n;
    n = 0;
    // let a preceding control write reach the lock outputs first
    repeat (2) @(posedge mclk);
    while (locks[idx] !== exp && n < 30000) begin
      @(posedge mclk);
      n++;
    end
    check(32'(locks[idx]), 32'(exp));
    rd_chk(scr_pkg::REG_STATUS, 32'h0000_0001 << idx, 32'(exp) << idx);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    error_cnt = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    run = '0;
    half_ns = 32'h0000_1458;
    repeat (5) @(posedge mclk);
    check({avs_waitrequest, rate_converter_en, locks, ring_flash, irq}, 32'h0000_0300);
    check({word_clk_out, aes_frame_sync}, 32'h0000_0000);
    @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd_chk(scr_pkg::REG_RATE_DIV, 32'h0000_FFFF, 32'h0000_0A2C);
    rd_chk(scr_pkg::REG_QUAL, 32'h0000_00FF, 32'h0000_0010);
    rd_chk(5'h18, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(scr_pkg::REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    wr(scr_pkg::REG_CTRL, 32'h0000_0007);
    rd_chk(scr_pkg::REG_CTRL, 32'h0000_0007, 32'h0000_0000);
    wr(scr_pkg::REG_RATE_DIV, 32'h0000_0010);
    wr(scr_pkg::REG_QUAL, 32'h0000_0004);
    wr(scr_pkg::REG_IRQ_MASK, 32'h0000_0007);
    // internal source, a live word clock on the input must not matter
    run <= 6'h01;
    watch(4000);
    check(32'(wc_rise), 32'd250);
    check(32'(wc_high), 32'd2000);
    check(32'(fs_cnt), 32'd250);
    check({29'h0, lock_or}, 32'h0000_0000);
    check(32'(rate_converter_en), 32'h0000_0001);
    // word clock reference while recording
    wr(scr_pkg::REG_CTRL, 32'h0000_0011);
    wait_lock(0, 1'b1);
    check(32'(rate_converter_en), 32'h0000_0000);
    check(32'(irq), 32'h0000_0001);
    rd_chk(scr_pkg::REG_IRQ_STAT, 32'h0000_0007, 32'h0000_0001);
    wr(scr_pkg::REG_IRQ_STAT, 32'h0000_0001);
    rd_chk(scr_pkg::REG_IRQ_STAT, 32'h0000_0007, 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    // reference lost mid-recording
    run <= 6'h00;
    wait_lock(0, 1'b0);
    rd_chk(scr_pkg::REG_IRQ_STAT, 32'h0000_0007, 32'h0000_0006);
    watch(320);
    check(32'(wc_rise), 32'd20);
    check(32'(ring_or != 4'h0), 32'h0000_0001);
    wr(scr_pkg::REG_IRQ_MASK, 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    wr(scr_pkg::REG_IRQ_MASK, 32'h0000_0007);
    check(32'(irq), 32'h0000_0001);
    wr(scr_pkg::REG_IRQ_STAT, 32'h0000_0006);
    check(32'(irq), 32'h0000_0000);
    // video sync at 50 kHz line rate
    wr(scr_pkg::REG_CTRL, 32'h0000_0002);
    half_ns <= 32'h0000_2710;
    run <= 6'h02;
    wait_lock(1, 1'b1);
    // aes pair 1-2 at 250 kHz is out of range and must not lock
    wr(scr_pkg::REG_CTRL, 32'h0000_0003);
    half_ns <= 32'h0000_07D0;
    run <= 6'h04;
    watch(6000);
    check({29'h0, lock_or}, 32'h0000_0000);
    check({28'h0, ring_or}, 32'h0000_0001);
    // every aes pair at 96 kHz
    half_ns <= 32'h0000_1458;
    for (int p = 0; p < 4; p++) begin
      wr(scr_pkg::REG_CTRL, 32'(p + 3));
      run <= 6'h04 << p;
      wait_lock(2, 1'b1);
      check(32'(rate_converter_en), 32'h0000_0000);
    end
    // locked to pair 7-8 at 1302 cycles per period: two frames in two periods
    watch(2604);
    check(32'(fs_cnt), 32'd2);
    check(32'(wc_rise), 32'd2);
    // playback drops the external reference
    wr(scr_pkg::REG_CTRL, 32'h0000_000E);
    wait_lock(2, 1'b0);
    watch(3000);
    check({29'h0, lock_or}, 32'h0000_0000);
    test_done();
  end
endmodule
`default_nettype wire
